// *** design/flow_pkg.sv ***
// How it works
// - Status bit 33 VLAN, 32 stacked, low reserved
// - Raise pause output on received XOFF
// - Load quanta counter; drop pause at expiry
// - Halt mode: stop TX, count while stopped
// - Otherwise count once per valid TX cycle
// - Quantum 512 bits; half or quarter step
// - Eight priority pause bits, set on PFC XOFF
// - Per-queue counters, drop bit at expiry
// - Status word valid only with its strobe
// - Bits 39 PFC, 35 PAUSE, 34 control; 38:36 reserved
package flow_pkg;

  // Receive status word layout
  localparam int STAT_W        = 40;
  localparam int STAT_PFC_BIT  = 39;
  localparam int STAT_PAUSE_BIT = 35;
  localparam int STAT_CTRL_BIT = 34;
  localparam int STAT_VLAN_BIT = 33;
  localparam int STAT_SVLAN_BIT = 32;

  // Quantum and counter geometry
  localparam int QUANTUM_BITS  = 512;
  localparam int QUANTA_W      = 16;
  localparam int FRAC_W        = 2;              // Quarter-quantum resolution
  localparam int CNT_W         = QUANTA_W + FRAC_W;
  localparam int NUM_PRIO      = 8;

  // Step per valid TX cycle, in quarter quanta
  localparam logic [CNT_W-1:0] STEP_100G = 18'h00002;  // One half
  localparam logic [CNT_W-1:0] STEP_50G  = 18'h00001;  // One quarter

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST   = 18'h00000;
  localparam logic [STAT_W-1:0] STAT_RST = 40'h0000000000;

  // Interrupt/control register map (word offsets on the plain port)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;
  localparam int IRQ_W = 3;                        // Pause on, pfc on, pause end
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;          // Bit0 halt mode, bit1 lanes4

  // Received frame classification from the parser
  typedef struct packed {
    logic                vld;    // One-cycle frame-end strobe
    logic                pfc;
    logic                pause;
    logic                ctrl;
    logic                vlan;
    logic                svlan;
    logic [QUANTA_W-1:0] pause_quanta;
    logic [NUM_PRIO-1:0] pfc_en;
    logic [NUM_PRIO*QUANTA_W-1:0] pfc_quanta;
  } rx_frame_s;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;

endpackage : flow_pkg

// *** design/quanta_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
// One quanta down-counter with quarter-quantum resolution
module quanta_counter (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              load,
  input  wire logic [flow_pkg::QUANTA_W-1:0]     quanta,
  input  wire logic                              dec,
  input  wire logic [flow_pkg::CNT_W-1:0]        step,
  output logic                                   active
);
  logic [flow_pkg::CNT_W-1:0] cnt_q;   // Remaining time, quarter quanta
  logic [flow_pkg::CNT_W-1:0] cnt_d;
  logic                       under;   // Step would reach or pass zero

  // Saturate at zero so a final fractional step expires cleanly
  assign under  = cnt_q <= step;
  // A fresh XOFF reloads even while counting; quanta 0 means resume
  assign cnt_d  = load ? {quanta, {flow_pkg::FRAC_W{1'b0}}}
                : (dec && cnt_q != flow_pkg::CNT_RST)
                  ? (under ? flow_pkg::CNT_RST : cnt_q - step)
                  : cnt_q;
  assign active = cnt_q != flow_pkg::CNT_RST;

  // Counter register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= flow_pkg::CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : quanta_counter
`default_nettype wire

// *** design/rx_pause_flow_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// Receive flow-control status: status word, pause and priority pause
module rx_pause_flow_status (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire flow_pkg::rx_frame_s           rx_frame,       // From RX parser
  input  wire logic                          tx_valid,       // TX client valid cycle
  input  wire logic                          tx_ready,       // TX client ready cycle
  input  wire flow_pkg::reg_req_s            reg_req,        // Register port
  output logic [31:0]                        reg_rdata,
  output logic                               rxstatus_valid,
  output logic [flow_pkg::STAT_W-1:0]        rxstatus_data,
  output logic                               rx_pause,
  output logic [flow_pkg::NUM_PRIO-1:0]      rx_pfc,
  output logic                               tx_halt,        // Stop TX MAC traffic
  output logic                               irq
);
  // Register state
  logic [1:0]                 ctrl_q;     // Bit0 halt on pause, bit1 four lanes
  logic [flow_pkg::IRQ_W-1:0] ists_q;     // Sticky events
  logic [flow_pkg::IRQ_W-1:0] imask_q;
  logic [31:0]                rdata_q;
  logic                       stv_q;
  logic [flow_pkg::STAT_W-1:0] std_q;
  logic                       pause_q;
  logic [flow_pkg::NUM_PRIO-1:0] pfc_q;
  logic                       halt_q;
  logic                       irq_q;

  // Decode
  wire halt_mode  = ctrl_q[0];
  wire four_lane  = ctrl_q[1];
  wire wr_ctrl    = reg_req.wr && reg_req.addr == flow_pkg::REG_CTRL;
  wire wr_irq     = reg_req.wr && reg_req.addr == flow_pkg::REG_IRQ;
  wire wr_mask    = reg_req.wr && reg_req.addr == flow_pkg::REG_MASK;
  wire [flow_pkg::CNT_W-1:0] step = four_lane ? flow_pkg::STEP_100G
                                              : flow_pkg::STEP_50G;
  wire tx_cycle   = tx_valid && tx_ready;
  // In halt mode the counter runs while traffic is held, else per valid beat
  wire pause_dec  = halt_mode ? 1'b1 : tx_cycle;
  wire pause_load = rx_frame.vld && rx_frame.pause;
  wire pause_act;
  wire [flow_pkg::NUM_PRIO-1:0] pfc_act;
  wire pfc_load_any = rx_frame.vld && rx_frame.pfc && (|rx_frame.pfc_en);

  // Status word: flags at their positions, reserved bits zero
  wire [flow_pkg::STAT_W-1:0] stat_word =
      ({{(flow_pkg::STAT_W-1){1'b0}}, rx_frame.pfc}   << flow_pkg::STAT_PFC_BIT)
    | ({{(flow_pkg::STAT_W-1){1'b0}}, rx_frame.pause} << flow_pkg::STAT_PAUSE_BIT)
    | ({{(flow_pkg::STAT_W-1){1'b0}}, rx_frame.ctrl}  << flow_pkg::STAT_CTRL_BIT)
    | ({{(flow_pkg::STAT_W-1){1'b0}}, rx_frame.vlan}  << flow_pkg::STAT_VLAN_BIT)
    | ({{(flow_pkg::STAT_W-1){1'b0}}, rx_frame.svlan} << flow_pkg::STAT_SVLAN_BIT);

  // Events: pause start, pfc start, pause end
  wire [flow_pkg::IRQ_W-1:0] ev = {pause_q && !pause_act, pfc_load_any, pause_load};
  // Set beats clear when both land in one cycle
  wire [flow_pkg::IRQ_W-1:0] ists_d = (ists_q & ~(wr_irq ? reg_req.wdata[flow_pkg::IRQ_W-1:0]
                                                           : flow_pkg::IRQ_RST)) | ev;
  // Next mask, so irq follows a mask write without a stale cycle
  wire [flow_pkg::IRQ_W-1:0] imask_d = wr_mask ? reg_req.wdata[flow_pkg::IRQ_W-1:0] : imask_q;

  // Read mux; unmapped addresses read zero
  logic [31:0] rmux;
  always_comb begin
    case (reg_req.addr)
      flow_pkg::REG_CTRL:   rmux = {30'h00000000, ctrl_q};
      flow_pkg::REG_STATUS: rmux = {22'h000000, halt_q, pfc_q, pause_q};
      flow_pkg::REG_IRQ:    rmux = {29'h00000000, ists_q};
      flow_pkg::REG_MASK:   rmux = {29'h00000000, imask_q};
      default:              rmux = 32'h00000000;
    endcase
  end

  // Main pause counter
  quanta_counter u_pause (
    .clk    (clk),
    .resetn (resetn),
    .load   (pause_load),
    .quanta (rx_frame.pause_quanta),
    .dec    (pause_dec),
    .step   (step),
    .active (pause_act)
  );

  // One counter per priority queue, each on every valid TX beat
  genvar g;
  generate
    for (g = 0; g < flow_pkg::NUM_PRIO; g++) begin : g_prio
      quanta_counter u_pfc (
        .clk    (clk),
        .resetn (resetn),
        .load   (rx_frame.vld && rx_frame.pfc && rx_frame.pfc_en[g]),
        .quanta (rx_frame.pfc_quanta[g*flow_pkg::QUANTA_W +: flow_pkg::QUANTA_W]),
        .dec    (tx_cycle),
        .step   (step),
        .active (pfc_act[g])
      );
    end
  endgenerate

  // Register port and interrupt state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= flow_pkg::CTRL_RST;
      ists_q  <= flow_pkg::IRQ_RST;
      imask_q <= flow_pkg::IRQ_RST;
      rdata_q <= 32'h00000000;
      irq_q   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_req.wdata[1:0];
      if (wr_mask) imask_q <= reg_req.wdata[flow_pkg::IRQ_W-1:0];
      ists_q  <= ists_d;
      rdata_q <= reg_req.rd ? rmux : 32'h00000000;
      irq_q   <= |(ists_d & imask_d);
    end
  end

  // Status strobe and flow outputs, all registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stv_q   <= 1'b0;
      std_q   <= flow_pkg::STAT_RST;
      pause_q <= 1'b0;
      pfc_q   <= '0;
      halt_q  <= 1'b0;
    end else begin
      stv_q   <= rx_frame.vld;
      // Zero the word outside valid cycles so stale flags never leak
      std_q   <= rx_frame.vld ? stat_word : flow_pkg::STAT_RST;
      pause_q <= pause_act;
      pfc_q   <= pfc_act;
      halt_q  <= halt_mode && pause_act;
    end
  end

  assign reg_rdata      = rdata_q;
  assign rxstatus_valid = stv_q;
  assign rxstatus_data  = std_q;
  assign rx_pause       = pause_q;
  assign rx_pfc         = pfc_q;
  assign tx_halt        = halt_q;
  assign irq            = irq_q;
endmodule : rx_pause_flow_status
`default_nettype wire

// *** bench/rx_pause_flow_status_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of status word and pause outputs
module rx_pause_flow_status_props (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire flow_pkg::rx_frame_s      rx_frame,
  input wire logic                     rxstatus_valid,
  input wire logic [39:0]              rxstatus_data,
  input wire logic                     rx_pause,
  input wire logic [7:0]               rx_pfc,
  input wire logic                     tx_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // XOFF requests with a count that must raise an output
  sequence pause_req;
    rx_frame.vld && rx_frame.pause && (rx_frame.pause_quanta != 16'h0000);
  endsequence
  sequence pfc3_req;
    rx_frame.vld && rx_frame.pfc && rx_frame.pfc_en[3] && (rx_frame.pfc_quanta[63:48] != 16'h0000);
  endsequence
  chk_status_follows_frame: assert property (rx_frame.vld |=> rxstatus_valid)
    else $error("status strobe missing after frame");
  chk_status_idle_zero: assert property (!rxstatus_valid |-> rxstatus_data == 40'h0000000000)
    else $error("status word not zero outside strobe");
  chk_vlan_bits: assert property (rx_frame.vld |=> rxstatus_data[33] == $past(rx_frame.vlan)
    && rxstatus_data[32] == $past(rx_frame.svlan)) else $error("vlan bits wrong");
  chk_reserved_zero: assert property (rxstatus_data[31:0] == 32'h0 && rxstatus_data[38:36] == 3'h0)
    else $error("reserved status bits set");
  chk_type_bits: assert property (rx_frame.vld |=> rxstatus_data[39] == $past(rx_frame.pfc)
    && rxstatus_data[35] == $past(rx_frame.pause) && rxstatus_data[34] == $past(rx_frame.ctrl))
    else $error("frame type bits wrong");
  chk_pause_rise: assert property (pause_req |-> ##2 rx_pause)
    else $error("pause output did not rise");
  chk_pfc_rise: assert property (pfc3_req |-> ##2 rx_pfc[3])
    else $error("priority pause bit did not rise");
  chk_halt_in_pause: assert property (tx_halt |-> rx_pause)
    else $error("halt without pause");
  chk_reset_clear: assert property ($rose(resetn) |-> !rx_pause && rx_pfc == 8'h00 && !tx_halt)
    else $error("pause outputs not clear after reset");
endmodule : rx_pause_flow_status_props
`default_nettype wire

// *** bench/tx_client_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Client logic: sends TX beats unless stalled or halted, samples status
module tx_client_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  input  wire logic        tx_halt,
  input  wire logic        rxstatus_valid,
  input  wire logic [39:0] rxstatus_data,
  output logic             tx_valid,
  output logic             tx_ready,
  output logic [39:0]      last_q
);
  // Halt honoured at once, so halt mode must count without beats
  assign tx_valid = !stall && !tx_halt;
  assign tx_ready = !stall;
  // Status word taken only in strobe cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) last_q <= 40'h0000000000;
    else if (rxstatus_valid) last_q <= rxstatus_data;
  end
endmodule : tx_client_model
`default_nettype wire

// *** bench/test_rx_pause_flow_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// Register, frame and pause-width tests
module test_rx_pause_flow_status;
  logic clk, resetn, stall, tx_valid, tx_ready, rxstatus_valid, rx_pause, tx_halt, irq, msel;
  flow_pkg::rx_frame_s rx_frame;
  flow_pkg::reg_req_s  reg_req;
  logic [31:0] reg_rdata, v;
  logic [39:0] rxstatus_data, last_q;
  logic [7:0]  rx_pfc;
  int          n_fail, total_checks;
  wire logic   mon = msel ? rx_pfc[3] : rx_pause; // Output under width test
  rx_pause_flow_status dut (.clk(clk), .resetn(resetn), .rx_frame(rx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rxstatus_valid(rxstatus_valid), .rxstatus_data(rxstatus_data), .rx_pause(rx_pause),
    .rx_pfc(rx_pfc), .tx_halt(tx_halt), .irq(irq));
  tx_client_model u_client (.clk(clk), .resetn(resetn), .stall(stall), .tx_halt(tx_halt),
    .rxstatus_valid(rxstatus_valid), .rxstatus_data(rxstatus_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .last_q(last_q));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task test_done;
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One-cycle register write and read
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) reg_req <= '0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk) reg_req <= '0;
    #1 d = reg_rdata;
  endtask : rd
  // Frame flags in order pfc, pause, ctrl, vlan, svlan
  task send(input logic [4:0] f, input logic [15:0] q, input logic [7:0] en);
    flow_pkg::rx_frame_s fr;
    fr = '0;
    {fr.vld, fr.pfc, fr.pause, fr.ctrl, fr.vlan, fr.svlan} = {1'b1, f};
    fr.pause_quanta = q;
    fr.pfc_en = en;
    fr.pfc_quanta = {8{q}};
    @(posedge clk) rx_frame <= fr;
    @(posedge clk) rx_frame <= '0;
  endtask : send
  // Cycles the watched output stays high, bounded wait
  task width(input int exp);
    int n;
    int k;
    n = 0;
    for (k = 0; k < 300 && !(n > 0 && mon !== 1'b1); k++) begin
      @(posedge clk);
      #1 if (mon === 1'b1) n++;
    end
    check(40'(n), 40'(exp));
  endtask : width
  initial begin
    #400000 n_fail++;
    test_done;
  end
  initial begin
    {resetn, stall, msel} = 3'b000;
    rx_frame = '0;
    reg_req = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1 check({rx_pfc, rx_pause, irq}, 40'h0);
    rd(4'hF, v);
    check(v, 40'h0); // Unmapped address reads zero
    wr(flow_pkg::REG_MASK, 32'h7);
    wr(flow_pkg::REG_CTRL, 32'h0);
    send(5'b01110, 16'h0001, 8'h00);
    width(4);
    check(last_q, 40'h0E00000000);
    check(irq, 40'h1); // Pause events unmasked
    rd(flow_pkg::REG_IRQ, v);
    check(v, 40'h5); // Pause start and end events
    wr(flow_pkg::REG_IRQ, 32'h7);
    rd(flow_pkg::REG_IRQ, v);
    check({v, irq}, 40'h0); // Cleared by writing ones
    wr(flow_pkg::REG_CTRL, 32'h2);
    stall <= 1'b1;
    send(5'b01000, 16'h0001, 8'h00);
    repeat (10) @(posedge clk);
    stall <= 1'b0;
    #1 check({tx_halt, rx_pause}, 40'h1);
    width(2);
    wr(flow_pkg::REG_CTRL, 32'h1);
    send(5'b01000, 16'h0002, 8'h00);
    @(posedge clk);
    #1 check({tx_halt, rx_pause}, 40'h3);
    width(7);
    wr(flow_pkg::REG_CTRL, 32'h2);
    msel <= 1'b1;
    send(5'b10000, 16'h0003, 8'h08);
    width(6);
    check(last_q, 40'h8000000000);
    rd(flow_pkg::REG_IRQ, v);
    check(v[1], 40'h1); // PFC event recorded
    // Reset in mid-pause must clear counters, not only the outputs
    send(5'b11000, 16'h0010, 8'hFF);
    @(posedge clk);
    #1 check({rx_pfc, rx_pause}, 40'h1FF);
    @(posedge clk) resetn <= 1'b0;
    #1 check({rx_pfc, rx_pause, tx_halt, irq}, 40'h0);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({rx_pfc, rx_pause, rxstatus_valid}, 40'h0);
    test_done;
  end
endmodule : test_rx_pause_flow_status
bind rx_pause_flow_status rx_pause_flow_status_props u_props (.clk(clk), .resetn(resetn),
  .rx_frame(rx_frame), .rxstatus_valid(rxstatus_valid), .rxstatus_data(rxstatus_data),
  .rx_pause(rx_pause), .rx_pfc(rx_pfc), .tx_halt(tx_halt));
`default_nettype wire
